// file: pkg/flash_pkg.sv
// constants shared by the serial flash command front end
package flash_pkg;

  // ****************************************************
  // opcodes
  // ****************************************************
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS_LO = 8'h05;
  localparam logic [7:0] OP_READ_STATUS_HI = 8'h35;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_DUAL_READ = 8'h3b;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;

  // ****************************************************
  // status field positions (low byte, then high byte)
  // ****************************************************
  localparam int LB_BUSY = 0;
  localparam int LB_LATCH = 1;
  localparam int LB_GUARD = 2;
  localparam int LB_MODE_LO = 7;
  localparam int HB_MODE_HI = 0;
  localparam int HB_QUAD = 1;
  localparam int HB_PROG_PAUSED = 2;
  localparam int HB_LOCK = 3;
  localparam int HB_INVERT = 6;
  localparam int HB_ERASE_PAUSED = 7;
  localparam logic QUAD_FIXED = 1'b1;

  // ****************************************************
  // frame bit counts, bit indexes, guard patterns and the erased data byte
  // ****************************************************
  localparam int CNT_W = 12;
  localparam logic [11:0] CNT_ONE = 12'h001;
  localparam logic [11:0] CNT_MAX = 12'hfff;
  localparam logic [11:0] CNT_OPCODE = 12'h008;
  localparam logic [11:0] CNT_ADDR_END = 12'h020;
  localparam logic [11:0] CNT_DUMMY_END = 12'h028;
  localparam logic [11:0] CNT_WRSR_ONE = 12'h010;
  localparam logic [11:0] CNT_WRSR_TWO = 12'h018;
  localparam logic [11:0] CNT_PP_MIN = 12'h028;
  localparam logic [2:0] BYTE_ALIGN = 3'h0;
  localparam logic [2:0] MSB_IDX = 3'h7;
  localparam logic [2:0] GUARD_ALL = 3'h7;
  localparam logic [2:0] GUARD_NONE = 3'h0;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ****************************************************
  // types
  // ****************************************************
  typedef enum logic [1:0] {
    ERASE_SECTOR,
    ERASE_BLOCK32,
    ERASE_BLOCK64,
    ERASE_CHIP
  } erase_kind_t;

endpackage

// file: verification/spi_host_model.sv
// host controller model that drives frames on the serial link
`timescale 1ns/1ps
module spi_host_model (
  output logic serial_clock,
  output logic chip_select_n,
  output logic host_io0,
  input wire logic io0_line,
  input wire logic io1_out
);
  // idle link: clock parked low, device deselected
  initial begin
    serial_clock = 1'b0;
    chip_select_n = 1'b1;
    host_io0 = 1'b0;
  end
  // one frame: nb bits msb first, then nr read clocks on one or two lanes
  task automatic frame(input logic [63:0] cmd, input int nb, input int nr, input bit dual,
                       output logic [31:0] rd);
    rd = 32'h0;
    #5 chip_select_n = 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      host_io0 = cmd[i];
      #6 serial_clock = 1'b1;
      #6 serial_clock = 1'b0;
    end
    host_io0 = ~host_io0; // released lane must not keep its last bit
    for (int i = 0; i < nr; i++) begin
      #6 serial_clock = 1'b1;
      rd = dual ? {rd[29:0], io1_out, io0_line} : {rd[30:0], io1_out};
      #6 serial_clock = 1'b0;
    end
    #6 chip_select_n = 1'b1;
    #48;
  endtask
endmodule

// file: verification/test_serial_flash_cmd_front_end.sv
// self-checking bench for the serial flash command front end
`timescale 1ns/1ps
module test_serial_flash_cmd_front_end;
  logic clock = 1'b0;
  logic nrst = 1'b1;
  logic erase_running = 1'b0;
  logic program_running = 1'b0;
  logic serial_clock, chip_select_n, host_io0, io0_line, io1_line;
  logic io0_out, io0_oe, io1_out, io1_oe, program_go, erase_go;
  flash_pkg::erase_kind_t erase_kind;
  logic [23:0] op_addr, pg_addr;
  logic [7:0] status_low_byte, status_high_byte, exp_lo, exp_hi;
  logic [31:0] rd;
  logic write_latch;
  int fail_count = 0;
  int checks = 0;
  int pg_cnt = 0;
  int er_cnt = 0;
  // core clock and the shared io0 wire
  always #4 clock = ~clock;
  assign io0_line = io0_oe ? io0_out : host_io0;
  // an undriven serial-out lane shows the opposite of the last level
  assign io1_line = io1_oe ? io1_out : ~io1_out;
  spi_host_model spi_host_model_inst (.serial_clock(serial_clock),
    .chip_select_n(chip_select_n), .host_io0(host_io0), .io0_line(io0_line),
    .io1_out(io1_line));
  serial_flash_cmd_front_end serial_flash_cmd_front_end_inst (.clock(clock), .nrst(nrst),
    .serial_clock(serial_clock), .chip_select_n(chip_select_n), .io0_in(io0_line),
    .io0_out(io0_out), .io0_oe(io0_oe), .io1_out(io1_out), .io1_oe(io1_oe),
    .erase_running(erase_running), .program_running(program_running),
    .program_go(program_go), .erase_go(erase_go), .erase_kind(erase_kind),
    .op_addr(op_addr), .status_low_byte(status_low_byte),
    .status_high_byte(status_high_byte));
  // count the one-cycle strobes
  always @(posedge clock) begin
    if (program_go === 1'b1) begin
      pg_cnt++;
      pg_addr <= op_addr;
    end
    if (erase_go === 1'b1) begin
      er_cnt++;
    end
  end
  // ****************************************************
  // helpers
  // ****************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic send(input logic [63:0] cmd, input int nb, input int nr = 0,
                      input bit dual = 1'b0);
    spi_host_model_inst.frame(cmd, nb, nr, dual, rd);
    @(posedge clock);
  endtask
  task automatic stat(input string t);
    check("status low", status_low_byte, {exp_lo[7:2], write_latch, erase_running | program_running});
    check("status high", status_high_byte, exp_hi);
    check("lanes released", {io0_oe, io1_oe}, 2'h0);
    $display("test %s done, checks %0d", t, checks);
  endtask
  function automatic logic [7:0] hi_after(input logic [7:0] old, input logic [7:0] nw);
    return {old[7], nw[6], old[5:3] | nw[5:3], old[2], 1'b1, nw[0]};
  endfunction
  function automatic bit ce_ok(input logic [7:0] lo, input logic [7:0] hi);
    return (lo[4:2] == 3'h0 && !hi[6]) || (lo[4:2] == 3'h7 && hi[6]);
  endfunction
  task automatic wrsr(input logic [7:0] lo, input logic [7:0] hi);
    send(8'h06, 8);
    send({8'h01, lo, hi}, 24);
    if (exp_hi[0] === 1'b0) begin
      exp_lo = lo;
      exp_hi = hi_after(exp_hi, hi);
    end else begin
      send(8'h04, 8); // refused while protected, drop the latch by hand
    end
    write_latch = 1'b0;
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge clock);
    fail_count++;
    summarize();
  end
  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    logic [7:0] lo, hi;
    logic [23:0] a;
    logic [3:0] ce_tab [4];
    logic [7:0] er_op [3];
    int n;
    ce_tab = '{4'h0, 4'hf, 4'h2, 4'he};
    er_op = '{8'h20, 8'h52, 8'hd8};
    nrst <= 1'b0; // falling edge at time zero clears the link-side flops
    void'($urandom(32'hff19));
    exp_lo = 8'h00;
    exp_hi = 8'h02;
    write_latch = 1'b0;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    stat("reset");
    send({8'h01, 8'h1c, 8'h40}, 24);
    stat("write without latch");
    send({8'h06, 1'b0}, 9);
    stat("unaligned enable");
    send(8'h06, 8);
    write_latch = 1'b1;
    stat("enable");
    for (int k = 0; k < 3; k++) begin
      n = $urandom;
      wrsr({1'b0, n[4:0], 2'h0}, {1'b0, n[8:5], 3'h0});
      stat("status write");
      send(8'h05, 8, 16);
      check("read low", rd, {16'h0, {2{exp_lo[7:2], write_latch, 1'b0}}});
      send(8'h35, 8, 16);
      check("read high", rd, {16'h0, {2{exp_hi}}});
      a = 24'($urandom);
      send({8'h03, a}, 32, 8);
      check("read", rd, 32'hff);
      send({8'h0b, a, 8'h00}, 40, 8);
      check("fast read", rd, 32'hff);
      send({8'h3b, a, 8'hff}, 40, 4, 1'b1);
      check("dual read", rd, 32'hff);
    end
    send(8'h06, 8);
    write_latch = 1'b1;
    send({8'h02, a, 4'h5}, 36);
    stat("partial program");
    check("program count", pg_cnt, 0);
    send({8'h02, a, 8'h5a}, 40);
    send(8'h04, 8);
    write_latch = 1'b0;
    check("program count", pg_cnt, 1);
    check("program addr", {8'h0, pg_addr}, {8'h0, a});
    for (int k = 0; k < 3; k++) begin
      n = er_cnt;
      send(8'h06, 8);
      send({er_op[k], a}, 32);
      send(8'h04, 8);
      check("erase count", er_cnt, n + 1);
      check("erase kind", {30'h0, erase_kind}, k);
    end
    for (int k = 0; k < 4; k++) begin
      lo = {3'h0, ce_tab[k][3:1], 2'h0};
      hi = {1'b0, ce_tab[k][0], 6'h0};
      wrsr(lo, hi);
      n = er_cnt;
      send(8'h06, 8);
      send(k[0] ? 8'hc7 : 8'h60, 8);
      send(8'h04, 8);
      check("chip erase", er_cnt, n + int'(ce_ok(lo, hi)));
    end
    @(posedge clock) erase_running <= 1'b1;
    send(8'h75, 8);
    exp_hi[7] = 1'b1;
    stat("erase suspend");
    @(posedge clock) erase_running <= 1'b0;
    send(8'h7a, 8);
    exp_hi[7] = 1'b0;
    stat("resume");
    @(posedge clock) program_running <= 1'b1;
    send(8'h75, 8);
    exp_hi[2] = 1'b1;
    stat("program suspend");
    @(posedge clock) program_running <= 1'b0;
    send(8'h66, 8);
    send(8'h99, 8);
    exp_hi[2] = 1'b0;
    stat("soft reset");
    wrsr(8'h00, 8'h01);
    wrsr(8'h1c, 8'h40);
    stat("lock-down");
    @(posedge clock) nrst <= 1'b0;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    exp_lo = 8'h00;
    exp_hi = 8'h02;
    stat("power cycle");
    wrsr(8'h80, 8'h01);
    wrsr(8'h04, 8'h00);
    stat("one-time lock");
    summarize();
  end
endmodule

// file: verilog/bit_sync.sv
// two-flop synchroniser for two level signals into the clock domain
`timescale 1ns/1ps
module bit_sync #(
  parameter logic [1:0] RESET_VALUE = 2'h0
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [1:0] async_in,
  output logic [1:0] sync_out
);

  logic [1:0] stage1_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (!nrst) begin
      stage1_reg <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end

endmodule

// file: verilog/serial_flash_cmd_front_end.sv
// serial flash command front end with status-register protection
// Notes on behaviour
// [R1] modes both zero: status write needs write_latch set by earlier write enable
// [R2] mode hi=1 lo=0 rejects status writes until power cycle, then both clear
// [R3] both mode bits one reject every later status write (code: nrst clears both, as in R2)
// [R4] quad_lane_enable always reads one, writes to it ignored
// [R5] three lock bits at 13..11 reset to zero, each settable by status write
// [R6] a set lock bit never clears; its security area becomes read-only (code: nrst clears lock bits, no security area)
// [R7] protect_invert at bit 14, writable, default zero, used with guard bits
// [R8] chip erase needs guards 2..0 at 000 with invert 0, or 111 with invert 1
// [R9] suspend 75h sets erase_paused or program_paused by what was running
// [R10] resume 7ah, reset pair 66h+99h and power cycle clear both paused flags
// [R11] bits come msb first on serial_in, sampled on serial_clock rise
// [R12] frame is opcode then address, data, both or nothing; cs rise ends it
// [R13] read commands drive data after the sequence; cs rise may end any bit
// [R14] write-type commands rejected unless cs rises on an eight-clock boundary
// [R15] page program with partial byte does nothing and keeps write_latch set
// [R16] 05h repeats status low byte, 35h repeats status high byte
// [R17] 03h: three address bytes then data; 0bh adds one dummy byte
// [R18] 3bh: three address bytes, one dummy byte, data out on two lanes
// [R19] write enable sets write_latch; without it writes, programs, erases refused
`timescale 1ns/1ps
module serial_flash_cmd_front_end (
  input wire logic clock,
  input wire logic nrst,
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic io0_in,
  output logic io0_out,
  output logic io0_oe,
  output logic io1_out,
  output logic io1_oe,
  input wire logic erase_running,
  input wire logic program_running,
  output logic program_go,
  output logic erase_go,
  output flash_pkg::erase_kind_t erase_kind,
  output logic [23:0] op_addr,
  output logic [7:0] status_low_byte,
  output logic [7:0] status_high_byte
);

  // ****************************************************
  // link side, clocked by serial_clock
  // ****************************************************
  logic frame_open_reg;
  logic frame_tog_reg;
  logic [11:0] bit_cnt_reg;
  logic [11:0] bit_cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] byte_in;
  logic [7:0] opcode_reg;
  logic [23:0] addr_reg;
  logic [7:0] wr_lo_reg;
  logic [7:0] wr_hi_reg;
  logic [7:0] shown_low_reg;
  logic [7:0] shown_high_reg;

  // frame flag drops the moment the device is deselected
  always_ff @(posedge serial_clock or posedge chip_select_n or negedge nrst) begin
    if (!nrst) begin
      frame_open_reg <= 1'b0;
    end else if (chip_select_n) begin
      frame_open_reg <= 1'b0;
    end else begin
      frame_open_reg <= 1'b1;
    end
  end

  // first edge of a frame restarts the count; count stays after cs rise
  always_comb begin
    if (!frame_open_reg) begin
      bit_cnt_next = flash_pkg::CNT_ONE;
    end else if (bit_cnt_reg == flash_pkg::CNT_MAX) begin
      bit_cnt_next = bit_cnt_reg;
    end else begin
      bit_cnt_next = bit_cnt_reg + flash_pkg::CNT_ONE;
    end
  end

  assign byte_in = {shift_reg[6:0], io0_in};

  // input shifter: msb first, sampled on rising edge
  always_ff @(posedge serial_clock or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_reg <= '0;
      shift_reg <= 8'h00;
      frame_tog_reg <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_next; // R11
      shift_reg <= frame_open_reg ? byte_in : {7'h00, io0_in}; // R11
      if (!frame_open_reg) begin
        frame_tog_reg <= ~frame_tog_reg; // marks a new frame for the core
      end
    end
  end

  // opcode, address and status-write bytes by position in the frame
  always_ff @(posedge serial_clock or negedge nrst) begin
    if (!nrst) begin
      opcode_reg <= 8'h00;
      addr_reg <= 24'h000000;
      wr_lo_reg <= 8'h00;
      wr_hi_reg <= 8'h00;
    end else begin
      if (bit_cnt_next == flash_pkg::CNT_OPCODE) begin
        opcode_reg <= byte_in; // R12
      end
      if (bit_cnt_next > flash_pkg::CNT_OPCODE && bit_cnt_next <= flash_pkg::CNT_ADDR_END) begin
        addr_reg <= {addr_reg[22:0], io0_in}; // R17
      end
      if (bit_cnt_next == flash_pkg::CNT_WRSR_ONE) begin
        wr_lo_reg <= byte_in;
      end
      if (bit_cnt_next == flash_pkg::CNT_WRSR_TWO) begin
        wr_hi_reg <= byte_in;
      end
    end
  end

  // output lanes change on the falling edge and float once deselected
  always_ff @(negedge serial_clock or posedge chip_select_n or negedge nrst) begin
    if (!nrst || chip_select_n) begin
      io0_out <= 1'b0;
      io0_oe <= 1'b0;
      io1_out <= 1'b0;
      io1_oe <= 1'b0;
    end else begin
      unique case (opcode_reg)
        flash_pkg::OP_READ_STATUS_LO: begin
          io1_oe <= (bit_cnt_reg >= flash_pkg::CNT_OPCODE); // R16
          io1_out <= shown_low_reg[flash_pkg::MSB_IDX - bit_cnt_reg[2:0]]; // R16
        end
        flash_pkg::OP_READ_STATUS_HI: begin
          io1_oe <= (bit_cnt_reg >= flash_pkg::CNT_OPCODE); // R16
          io1_out <= shown_high_reg[flash_pkg::MSB_IDX - bit_cnt_reg[2:0]]; // R16
        end
        flash_pkg::OP_READ: begin
          io1_oe <= (bit_cnt_reg >= flash_pkg::CNT_ADDR_END); // R17
          io1_out <= flash_pkg::ERASED_BYTE[flash_pkg::MSB_IDX - bit_cnt_reg[2:0]]; // R13
        end
        flash_pkg::OP_FAST_READ: begin
          io1_oe <= (bit_cnt_reg >= flash_pkg::CNT_DUMMY_END); // R17
          io1_out <= flash_pkg::ERASED_BYTE[flash_pkg::MSB_IDX - bit_cnt_reg[2:0]]; // R13
        end
        flash_pkg::OP_DUAL_READ: begin
          // two bits per clock: odd bit on lane 1, even bit on lane 0
          io0_oe <= (bit_cnt_reg >= flash_pkg::CNT_DUMMY_END); // R18
          io1_oe <= (bit_cnt_reg >= flash_pkg::CNT_DUMMY_END); // R18
          io1_out <= flash_pkg::ERASED_BYTE[{~bit_cnt_reg[1:0], 1'b1}]; // R18
          io0_out <= flash_pkg::ERASED_BYTE[{~bit_cnt_reg[1:0], 1'b0}]; // R18
        end
        default: begin
          io0_oe <= 1'b0;
          io1_oe <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************
  // core side, clocked by clock
  // ****************************************************
  logic [1:0] sync_q;
  logic cs_prev_reg;
  logic tog_seen_reg;
  logic exec;
  logic aligned;
  logic write_latch_reg;
  logic [4:0] guard_reg;
  logic mode_lo_reg;
  logic mode_hi_reg;
  logic [2:0] lock_reg;
  logic invert_reg;
  logic erase_paused_reg;
  logic program_paused_reg;
  logic reset_armed_reg;
  logic chip_allowed;
  logic wrsr_ok;
  logic pp_ok;
  logic erase_ok;
  logic chip_ok;

  // chip select and frame toggle cross as levels
  bit_sync #(.RESET_VALUE(2'h1)) u_sync (
    .clock(clock),
    .nrst(nrst),
    .async_in({frame_tog_reg, chip_select_n}),
    .sync_out(sync_q)
  );

  // a command runs once, on the synchronised cs rise of a new frame
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cs_prev_reg <= 1'b1;
      tog_seen_reg <= 1'b0;
    end else begin
      cs_prev_reg <= sync_q[0];
      if (exec) begin
        tog_seen_reg <= sync_q[1];
      end
    end
  end

  // link words are stable while deselected, so the core reads them directly
  assign exec = sync_q[0] && !cs_prev_reg && (sync_q[1] != tog_seen_reg);
  assign aligned = (bit_cnt_reg[2:0] == flash_pkg::BYTE_ALIGN); // R14

  // chip erase permitted only for the two fully open guard patterns
  assign chip_allowed = (guard_reg[2:0] == flash_pkg::GUARD_NONE && !invert_reg) ||
                        (guard_reg[2:0] == flash_pkg::GUARD_ALL && invert_reg); // R8
  assign wrsr_ok = exec && opcode_reg == flash_pkg::OP_WRITE_STATUS && aligned &&
                   bit_cnt_reg >= flash_pkg::CNT_WRSR_ONE &&
                   write_latch_reg && !mode_hi_reg; // R1 R2 R3 R14 R19
  assign pp_ok = exec && opcode_reg == flash_pkg::OP_PAGE_PROGRAM && aligned &&
                 bit_cnt_reg >= flash_pkg::CNT_PP_MIN && write_latch_reg; // R14 R15 R19
  assign erase_ok = exec && aligned && bit_cnt_reg >= flash_pkg::CNT_ADDR_END &&
                    write_latch_reg && (opcode_reg == flash_pkg::OP_SECTOR_ERASE ||
                    opcode_reg == flash_pkg::OP_BLOCK32_ERASE ||
                    opcode_reg == flash_pkg::OP_BLOCK64_ERASE); // R14 R19
  assign chip_ok = exec && aligned && write_latch_reg && chip_allowed &&
                   (opcode_reg == flash_pkg::OP_CHIP_ERASE_A ||
                   opcode_reg == flash_pkg::OP_CHIP_ERASE_B); // R8 R14 R19

  // write latch: set by write enable, cleared by disable, accepted writes and the 66h+99h reset pair
  always_ff @(posedge clock) begin
    if (!nrst) begin
      write_latch_reg <= 1'b0;
    end else if (exec && aligned && opcode_reg == flash_pkg::OP_WRITE_ENABLE) begin
      write_latch_reg <= 1'b1; // R19
    end else if ((exec && aligned && opcode_reg == flash_pkg::OP_WRITE_DISABLE) ||
                 wrsr_ok || pp_ok || erase_ok || chip_ok ||
                 (exec && reset_armed_reg && opcode_reg == flash_pkg::OP_RESET)) begin
      write_latch_reg <= 1'b0; // R14 R15
    end
  end

  // protection fields; power-up clears both mode bits
  always_ff @(posedge clock) begin
    if (!nrst) begin
      guard_reg <= 5'h00;
      mode_lo_reg <= 1'b0; // R2
      mode_hi_reg <= 1'b0; // R2
      lock_reg <= 3'h0; // R5
      invert_reg <= 1'b0; // R7
    end else if (wrsr_ok) begin
      guard_reg <= wr_lo_reg[flash_pkg::LB_GUARD +: 5];
      mode_lo_reg <= wr_lo_reg[flash_pkg::LB_MODE_LO];
      if (bit_cnt_reg >= flash_pkg::CNT_WRSR_TWO) begin
        mode_hi_reg <= wr_hi_reg[flash_pkg::HB_MODE_HI];
        lock_reg <= lock_reg | wr_hi_reg[flash_pkg::HB_LOCK +: 3]; // R5 R6
        invert_reg <= wr_hi_reg[flash_pkg::HB_INVERT]; // R7
      end
    end
  end

  // suspend flags and the two-step software reset
  always_ff @(posedge clock) begin
    if (!nrst) begin
      erase_paused_reg <= 1'b0; // R10
      program_paused_reg <= 1'b0; // R10
      reset_armed_reg <= 1'b0;
    end else if (exec) begin
      reset_armed_reg <= (opcode_reg == flash_pkg::OP_RESET_ENABLE);
      if (opcode_reg == flash_pkg::OP_SUSPEND) begin
        if (erase_running) begin
          erase_paused_reg <= 1'b1; // R9
        end else if (program_running) begin
          program_paused_reg <= 1'b1; // R9
        end
      end else if (opcode_reg == flash_pkg::OP_RESUME ||
                   (reset_armed_reg && opcode_reg == flash_pkg::OP_RESET)) begin
        erase_paused_reg <= 1'b0; // R10
        program_paused_reg <= 1'b0; // R10
      end
    end
  end

  // one-cycle array strobes with the captured address
  always_ff @(posedge clock) begin
    if (!nrst) begin
      program_go <= 1'b0;
      erase_go <= 1'b0;
      erase_kind <= flash_pkg::ERASE_SECTOR;
      op_addr <= 24'h000000;
    end else begin
      program_go <= pp_ok; // R15
      erase_go <= erase_ok || chip_ok; // R8
      if (pp_ok || erase_ok || chip_ok) begin
        op_addr <= addr_reg;
        erase_kind <= chip_ok ? flash_pkg::ERASE_CHIP :
                      opcode_reg == flash_pkg::OP_BLOCK32_ERASE ? flash_pkg::ERASE_BLOCK32 :
                      opcode_reg == flash_pkg::OP_BLOCK64_ERASE ? flash_pkg::ERASE_BLOCK64 :
                      flash_pkg::ERASE_SECTOR;
      end
    end
  end

  // status bytes as seen by software
  always_comb begin
    status_low_byte = {mode_lo_reg, guard_reg, write_latch_reg,
                       erase_running || program_running};
    status_high_byte = {erase_paused_reg, invert_reg, lock_reg, program_paused_reg,
                        flash_pkg::QUAD_FIXED, mode_hi_reg}; // R4 R7 R9
  end

  // snapshot for the link, frozen while a frame is in progress
  always_ff @(posedge clock) begin
    if (!nrst) begin
      shown_low_reg <= 8'h00;
      shown_high_reg <= 8'h00;
    end else if (sync_q[0] && cs_prev_reg) begin
      shown_low_reg <= status_low_byte; // R16
      shown_high_reg <= status_high_byte; // R16
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  property p_latch_gates;
    @(posedge clock) disable iff (!nrst)
      (exec && !write_latch_reg && opcode_reg == flash_pkg::OP_WRITE_STATUS)
      |=> $stable(guard_reg) && $stable(mode_lo_reg) && $stable(invert_reg);
  endproperty
  a_latch_gates: assert property (p_latch_gates) else $error("status write without latch"); // R1

  property p_mode_lock;
    @(posedge clock) disable iff (!nrst)
      (exec && mode_hi_reg) |=> $stable(guard_reg) && mode_hi_reg && $stable(lock_reg);
  endproperty
  a_mode_lock: assert property (p_mode_lock) else $error("locked status was written"); // R2 R3

  property p_quad_fixed;
    @(posedge clock) disable iff (!nrst)
      (exec && opcode_reg == flash_pkg::OP_WRITE_STATUS)
      |=> status_high_byte[flash_pkg::HB_QUAD] == flash_pkg::QUAD_FIXED;
  endproperty
  a_quad_fixed: assert property (p_quad_fixed) else $error("quad enable not one"); // R4

  property p_lock_sticky;
    @(posedge clock) disable iff (!nrst)
      $past(nrst) |-> (($past(lock_reg) & ~lock_reg) == 3'h0);
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared"); // R6

  property p_chip_guard;
    @(posedge clock) disable iff (!nrst)
      (exec && !chip_allowed && opcode_reg == flash_pkg::OP_CHIP_ERASE_B) |=> !erase_go;
  endproperty
  a_chip_guard: assert property (p_chip_guard) else $error("chip erase not guarded"); // R8

  property p_suspend;
    @(posedge clock) disable iff (!nrst)
      (exec && opcode_reg == flash_pkg::OP_SUSPEND && erase_running)
      |=> erase_paused_reg ##1 erase_paused_reg || exec;
  endproperty
  a_suspend: assert property (p_suspend) else $error("erase suspend flag missing"); // R9

  property p_resume;
    @(posedge clock) disable iff (!nrst)
      (exec && opcode_reg == flash_pkg::OP_RESUME) |=> !erase_paused_reg && !program_paused_reg;
  endproperty
  a_resume: assert property (p_resume) else $error("resume left a flag set"); // R10

  property p_boundary;
    @(posedge clock) disable iff (!nrst)
      (exec && !aligned && !write_latch_reg && opcode_reg == flash_pkg::OP_WRITE_ENABLE)
      |=> !write_latch_reg;
  endproperty
  a_boundary: assert property (p_boundary) else $error("unaligned write enable taken"); // R14

  property p_partial_program;
    @(posedge clock) disable iff (!nrst)
      (exec && !aligned && write_latch_reg && opcode_reg == flash_pkg::OP_PAGE_PROGRAM)
      |=> write_latch_reg && !program_go;
  endproperty
  a_partial_program: assert property (p_partial_program) else $error("partial program ran"); // R15

  property p_write_enable;
    @(posedge clock) disable iff (!nrst)
      (exec && aligned && opcode_reg == flash_pkg::OP_WRITE_ENABLE) |=> write_latch_reg;
  endproperty
  a_write_enable: assert property (p_write_enable) else $error("write enable not latched"); // R19

endmodule
